//--- prm_routing_matrix.v
// Peripheral pin routing matrix with AXI4-Lite register access.
// Assumes pins come from outside the clock domain; analog pins bypass it.
`timescale 1ns/1ps
`include "prm_defines.vh"
module prm_routing_matrix (
  input wire clk,
  input wire rst,
  input wire porRst,
  input wire oneTimeLockOption,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [`PRM_NUM_PIN-1:0] pinIn,
  input wire [`PRM_NUM_SRC-1:0] periphOut,
  input wire [`PRM_NUM_SRC-1:0] periphOe,
  input wire [`PRM_NUM_PIN-1:0] pinDirOut,
  output reg [`PRM_NUM_IN-1:0] periphIn,
  output reg [`PRM_NUM_PIN-1:0] pinOut,
  output reg [`PRM_NUM_PIN-1:0] pinOe,
  output reg routingLocked
);
  // Pin order: A0..A5, B4..B7, C0..C7. Only digital paths here.
  // Selector storage: reset only by power-on reset, so system resets keep them.
  reg [`PRM_SEL_W-1:0] inSel_q [0:`PRM_NUM_IN-1];
  reg [`PRM_SEL_W-1:0] outSel_q [0:`PRM_NUM_PIN-1];
  reg locked_q;
  reg [1:0] seq_q;
  reg oneTimeUsed_q;
  reg oneTimeStrap_q;
  reg porSeen_q;

  // Pin synchronisers: change counts once stages two and three agree
  reg [`PRM_NUM_PIN-1:0] pinS1_q;
  reg [`PRM_NUM_PIN-1:0] pinS2_q;
  reg [`PRM_NUM_PIN-1:0] pinS3_q;
  reg [`PRM_NUM_PIN-1:0] pinClean_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pinS1_q <= {`PRM_NUM_PIN{1'b0}};
      pinS2_q <= {`PRM_NUM_PIN{1'b0}};
      pinS3_q <= {`PRM_NUM_PIN{1'b0}};
      pinClean_q <= {`PRM_NUM_PIN{1'b0}};
    end else begin
      pinS1_q <= pinIn;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      pinClean_q <= (pinS2_q & pinS3_q) | (pinClean_q & (pinS2_q | pinS3_q));
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  reg awHave_q;
  reg wHave_q;
  reg [11:0] awAddr_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  wire wrGo = awHave_q && wHave_q && !s_axi_bvalid;
  wire [11:0] wa = awAddr_q;
  wire inHit = (wa[11:2] >= (`PRM_IN_BASE >> 2)) && (wa[11:2] < ((`PRM_IN_BASE >> 2) + `PRM_NUM_IN));
  wire outHit = (wa[11:2] >= (`PRM_OUT_BASE >> 2)) && (wa[11:2] < ((`PRM_OUT_BASE >> 2) + `PRM_NUM_PIN));
  wire lockHit = (wa[11:2] == (`PRM_LOCK_ADDR >> 2));
  wire statHit = (wa[11:2] == (`PRM_STAT_ADDR >> 2));
  // Offsets kept at full address width so the subtraction drops no bits
  wire [11:0] inIdx = {2'b00, wa[11:2]} - (`PRM_IN_BASE >> 2);
  wire [11:0] outIdx = {2'b00, wa[11:2]} - (`PRM_OUT_BASE >> 2);
  wire selWr = wrGo && wStrb_q[0] && !locked_q;
  wire lockWr = wrGo && lockHit && wStrb_q[0];
  wire [7:0] wByte = wData_q[7:0];
  wire lockChangeOk = (seq_q == 2'd2) && !(oneTimeStrap_q && oneTimeUsed_q);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 12'h000;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wrGo) begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (inHit || outHit || lockHit || statHit) ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Power-on domain: selectors and lock flag; sequence state sits in the rst domain.
  // Sleep has no input here; nothing but writes and power-on reset touches selectors.
  integer k;
  always @(posedge clk or posedge porRst) begin
    if (porRst) begin
      for (k = 0; k < `PRM_NUM_IN; k = k + 1)
        inSel_q[k] <= `PRM_IN_RST;
      for (k = 0; k < `PRM_NUM_PIN; k = k + 1)
        outSel_q[k] <= `PRM_OUT_RST;
      locked_q <= 1'b0;
    end else begin
      if (selWr && inHit)
        inSel_q[inIdx[2:0]] <= wByte[4:0];
      if (selWr && outHit)
        outSel_q[outIdx[4:0]] <= wByte[4:0];
      if (lockWr && lockChangeOk)
        locked_q <= wByte[`PRM_LOCKED_BIT];
    end
  end

  // Sequence and one-time tracking follow the system reset rst only, not porRst
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_q <= 2'd0;
      oneTimeUsed_q <= 1'b0;
      oneTimeStrap_q <= 1'b0;
      porSeen_q <= 1'b0;
    end else begin
      // Strap caught once after reset release
      if (!porSeen_q) begin
        oneTimeStrap_q <= oneTimeLockOption;
        porSeen_q <= 1'b1;
      end
      if (wrGo) begin
        if (lockHit && wStrb_q[0] && wByte == `PRM_KEY1)
          seq_q <= 2'd1;
        else if (lockHit && wStrb_q[0] && wByte == `PRM_KEY2 && seq_q == 2'd1)
          seq_q <= 2'd2;
        else
          seq_q <= 2'd0;
      end
      if (lockWr && lockChangeOk)
        oneTimeUsed_q <= 1'b1;
    end
  end

  // AXI4-Lite read path, selectors readable whatever the lock state
  wire [11:0] ra = s_axi_araddr;
  wire [11:0] rInIdx = {2'b00, ra[11:2]} - (`PRM_IN_BASE >> 2);
  wire [11:0] rOutIdx = {2'b00, ra[11:2]} - (`PRM_OUT_BASE >> 2);
  reg [31:0] rdVal;
  reg rdOk;
  always @* begin
    rdVal = 32'h0000_0000;
    rdOk = 1'b1;
    if (ra[11:2] >= (`PRM_IN_BASE >> 2) && ra[11:2] < ((`PRM_IN_BASE >> 2) + `PRM_NUM_IN))
      rdVal = {27'h0000000, inSel_q[rInIdx[2:0]]};
    else if (ra[11:2] >= (`PRM_OUT_BASE >> 2) && ra[11:2] < ((`PRM_OUT_BASE >> 2) + `PRM_NUM_PIN))
      rdVal = {27'h0000000, outSel_q[rOutIdx[4:0]]};
    else if (ra[11:2] == (`PRM_LOCK_ADDR >> 2))
      rdVal = {31'h00000000, locked_q};
    else if (ra[11:2] == (`PRM_STAT_ADDR >> 2))
      rdVal = {28'h0000000, seq_q, oneTimeUsed_q, oneTimeStrap_q};
    else
      rdOk = 1'b0;
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdVal;
        s_axi_rresp <= rdOk ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Input side: one multiplexer per peripheral input, all sharing one coding
  wire [`PRM_NUM_IN-1:0] inPick;
  genvar g;
  generate
    for (g = 0; g < `PRM_NUM_IN; g = g + 1) begin : gIn
      prm_in_mux uMux (
        .clk(clk),
        .rst(rst),
        .sel(inSel_q[g]),
        .pins(pinClean_q),
        .pick_q(inPick[g])
      );
    end
  endgenerate

  // Direction override for sync serial and two-wire sources
  function isOverrideSrc;
    input [4:0] c;
    begin
      isOverrideSrc = (c == `PRM_OUT_SYNC_CLK) || (c == `PRM_OUT_SYNC_DAT) ||
        (c == `PRM_OUT_SER_TX) || (c == `PRM_OUT_SER_DT);
    end
  endfunction

  // Reserved codes 0 and 1 drive low; bidirectional pairing is software's job
  integer p;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      periphIn <= {`PRM_NUM_IN{1'b0}};
      pinOut <= {`PRM_NUM_PIN{1'b0}};
      pinOe <= {`PRM_NUM_PIN{1'b0}};
      routingLocked <= 1'b0;
    end else begin
      periphIn <= inPick;
      routingLocked <= locked_q;
      for (p = 0; p < `PRM_NUM_PIN; p = p + 1) begin
        pinOut[p] <= (outSel_q[p] > 5'h01) ? periphOut[outSel_q[p]] : 1'b0;
        if (isOverrideSrc(outSel_q[p]))
          pinOe[p] <= periphOe[outSel_q[p]];
        else
          pinOe[p] <= pinDirOut[p];
      end
    end
  end
endmodule

//--- prm_defines.vh
// Constants for the peripheral pin routing matrix.
// Assumes inclusion by bare name from the design files.
// How it works
// - Only digital signals pass the matrix
// - Each peripheral input has own selector
// - Input codes pick port A, B, C pins
// - Input selector bits 7-5 read zero
// - Each pin has own output selector
// - Serial peripherals may override pin direction
// - Lock bit blocks all selector writes
// - Lock changes only after 0x55, 0xAA
// - One-time option: one lock change per reset
// - Without option, lock changes unlimited times
// - Selectors always readable
// - Sleep leaves selections untouched
// - Power-on reset restores defaults, clears lock
// - Other resets keep selector contents
// - Output code picks driving peripheral source
// - Lock flag at bit 0 of lock register
`ifndef PRM_DEFINES_VH
`define PRM_DEFINES_VH
`define PRM_NUM_IN 8
`define PRM_NUM_PIN 18
`define PRM_NUM_SRC 32
`define PRM_SEL_W 5
`define PRM_IN_BASE 12'h000
`define PRM_OUT_BASE 12'h040
`define PRM_LOCK_ADDR 12'h100
`define PRM_STAT_ADDR 12'h104
`define PRM_LOCKED_BIT 0
`define PRM_KEY1 8'h55
`define PRM_KEY2 8'hAA
`define PRM_IN_RST 5'h00
`define PRM_OUT_RST 5'h00
`define PRM_OUT_MOD 5'h1F
`define PRM_OUT_SYNC_CLK 5'h18
`define PRM_OUT_SYNC_DAT 5'h19
`define PRM_OUT_SER_TX 5'h14
`define PRM_OUT_SER_DT 5'h15
`endif

//--- prm_in_mux.v
// One peripheral input source multiplexer over the pin bank.
// Assumes pins are already synchronised to clk.
`timescale 1ns/1ps
`include "prm_defines.vh"
module prm_in_mux (
  input wire clk,
  input wire rst,
  input wire [`PRM_SEL_W-1:0] sel,
  input wire [`PRM_NUM_PIN-1:0] pins,
  output reg pick_q
);
  // Code to pin index, reserved codes give index 31 (no pin, reads low)
  function [4:0] codeToPin;
    input [4:0] c;
    begin
      if (c <= 5'h05)
        codeToPin = c;
      else if (c >= 5'h0C && c <= 5'h0F)
        codeToPin = c - 5'h06;
      else if (c >= 5'h10 && c <= 5'h17)
        codeToPin = c - 5'h06;
      else
        codeToPin = 5'h1F;
    end
  endfunction
  wire [4:0] idx = codeToPin(sel);
  always @(posedge clk or posedge rst) begin
    if (rst)
      pick_q <= 1'b0;
    else
      pick_q <= (idx < `PRM_NUM_PIN) ? pins[idx] : 1'b0;
  end
endmodule

//--- prm_asserts.sv
// Bus handshake and register checks on the routing matrix ports.
// Assumes one clock domain; bound to every matrix instance.
`timescale 1ns/1ps
module prm_asserts (
  input logic clk,
  input logic rst,
  input logic porRst,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [11:0] s_axi_araddr,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic routingLocked
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Both halves are latched first, the answer follows one cycle later
  wr_answer_a: assert property (wrTaken |-> ##2 s_axi_bvalid) else $error("write answer late");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write ready early");
  rd_answer_a: assert property (rdTaken |=> s_axi_rvalid) else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  sel_read_a: assert property (
    rdTaken ##0 s_axi_araddr < 12'h020 |=> s_axi_rresp == 2'h0 && s_axi_rdata[31:5] == 27'h0)
    else $error("selector read wrong");
  unmapped_rd_a: assert property (rdTaken ##0 s_axi_araddr > 12'h107 |=> s_axi_rresp == 2'h2)
    else $error("unmapped read accepted");
  por_lock_a: assert property (porRst ##1 porRst |-> !routingLocked) else $error("lock kept in POR");
endmodule
bind prm_routing_matrix prm_asserts u_prm_asserts (.*);

//--- prm_far_side.sv
// Far side: peripheral outputs and pads that loop back to inputs.
// Assumes the bench sets pad levels and source values.
`timescale 1ns/1ps
module prm_far_side (
  input logic [17:0] pinOut,
  input logic [17:0] pinOe,
  input logic [17:0] extLevel,
  input logic [31:0] srcVal,
  input logic [31:0] srcOe,
  output logic [17:0] pinIn,
  output logic [31:0] periphOut,
  output logic [31:0] periphOe
);
  // A driven pad reads back its own level, as a shared line does
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
  assign periphOut = srcVal;
  assign periphOe = srcOe;
endmodule

//--- testbench.sv
// Self-checking bench for the routing matrix over AXI4-Lite.
// Assumes the far-side model and checker compile first.
`timescale 1ns/1ps
`include "prm_defines.vh"
module testbench;
  localparam logic [11:0] lockAddr = `PRM_LOCK_ADDR;
  logic clk = 0, rst = 1, porRst = 1, oneTimeLockOption = 0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, srcVal = 32'h8000_0001, srcOe = '0, periphOut, periphOe, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, routingLocked;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [17:0] pinIn, pinOut, pinOe, pinDirOut = '0, extLevel = '0;
  logic [7:0] periphIn;
  int n_errors = 0, checks_done = 0, cyc = 0;
  prm_routing_matrix u_prm_routing_matrix (.*);
  prm_far_side u_prm_far_side (.*);
  always #25 clk = ~clk;
  // A hung handshake would otherwise stall the run for ever
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      end_sim;
    end
  end
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input [31:0] e, input [31:0] s);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr(input [11:0] a, input [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    resp = s_axi_bresp;
  endtask
  task automatic rdr(input [11:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    rd = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  task automatic rchk(input string nm, input [11:0] a, input [31:0] e);
    rdr(a);
    chk(nm, e, rd);
  endtask
  // Nothing else is written between the three steps
  task automatic lockSeq(input [31:0] v);
    wr(lockAddr, `PRM_KEY1);
    wr(lockAddr, `PRM_KEY2);
    wr(lockAddr, v);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    porRst <= 0;
    rchk("inSel", 12'h000, 0);
    rchk("lock", lockAddr, 0);
    for (int c = 0; c < 24; c++) begin
      if (c < 6 || c > 11) begin
        wr(12'(4 * (c % 8)), c);
        extLevel <= 18'h1 << (c < 6 ? c : c - 6);
        repeat (8) @(posedge clk);
        chk("routeHi", 1, periphIn[c % 8]);
        extLevel <= ~extLevel;
        repeat (8) @(posedge clk);
        chk("routeLo", 0, periphIn[c % 8]);
      end
    end
    extLevel <= '0;
    wr(12'h000, 32'h10);
    wr(`PRM_OUT_BASE + 12'h028, `PRM_OUT_SYNC_CLK);
    srcOe <= 32'h0100_0000;
    srcVal <= 32'h8100_0001;
    pinDirOut <= 18'h8;
    wr(`PRM_OUT_BASE + 12'h00C, `PRM_OUT_MOD);
    repeat (8) @(posedge clk);
    chk("oeOvr", 1, pinOe[10]);
    chk("loop", 1, periphIn[0]);
    chk("modOut", 1, pinOut[3]);
    chk("dirOe", 1, pinOe[3]);
    wr(`PRM_OUT_BASE + 12'h00C, 32'h0);
    repeat (2) @(posedge clk);
    chk("rsvdOut", 0, pinOut[3]);
    wr(12'h004, 32'hEF);
    rchk("upper", 12'h004, 32'h0F);
    wr(12'h200, 1);
    chk("bresp", 2, resp);
    rdr(12'h200);
    chk("rresp", 2, resp);
    wr(lockAddr, `PRM_KEY1);
    wr(12'h004, 3);
    wr(lockAddr, `PRM_KEY2);
    wr(lockAddr, 1);
    rchk("broken", lockAddr, 0);
    lockSeq(1);
    rchk("locked", lockAddr, 1);
    chk("flag", 1, routingLocked);
    wr(12'h004, 7);
    rchk("frozen", 12'h004, 3);
    for (int k = 0; k < 3; k++) begin
      lockSeq(k % 2);
      rchk("multi", lockAddr, k % 2);
    end
    lockSeq(1);
    oneTimeLockOption <= 1;
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    rchk("keepSel", 12'h004, 3);
    rchk("keepLock", lockAddr, 1);
    lockSeq(0);
    lockSeq(1);
    rchk("oneTime", lockAddr, 0);
    rchk("status", `PRM_STAT_ADDR, 32'h3);
    rst <= 1;
    porRst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    repeat (4) @(posedge clk);
    porRst <= 0;
    rchk("porSel", 12'h004, 0);
    rchk("porLock", lockAddr, 0);
    end_sim;
  end
endmodule
